// >>> dsc_byte_fifo.sv
`timescale 1ns/100ps
module dsc_byte_fifo
  import dsc_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = DMA_FIFO_BYTES
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH+1)-1:0] level
);
  localparam int PW = $clog2(DEPTH);
  localparam int LW = $clog2(DEPTH+1);
  localparam logic [LW-1:0] FULL_LEVEL = LW'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH-1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  logic [LW-1:0] next_level;
  logic push, pop;

  // honest full and empty straight from the level
  assign in_ready = (level != FULL_LEVEL);
  assign out_valid = (level != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // pointer and level update
  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_level = level;
    if (push) begin
      next_wr_ptr = (wr_ptr == LAST_PTR) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == LAST_PTR) ? '0 : rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_level = level + 1'b1;
    end else if (pop && !push) begin
      next_level = level - 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      level <= next_level;
    end
  end

  // storage needs no reset; only valid entries are ever read out
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule : dsc_byte_fifo

// >>> dsc_dma_core.sv
`timescale 1ns/100ps
module dsc_dma_core
  import dsc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic usb_bus_reset,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq,
  // external dma bus, in direction
  input wire logic dma_in_valid,
  input wire logic [7:0] dma_in_data,
  output logic dma_in_ready,
  // external dma bus, out direction
  output logic dma_out_valid,
  output logic [7:0] dma_out_data,
  input wire logic dma_out_ready,
  // endpoint buffer, in direction
  output logic ep_in_valid,
  output logic [7:0] ep_in_data,
  input wire logic ep_in_ready,
  // endpoint buffer, out direction
  input wire logic ep_out_valid,
  input wire logic [7:0] ep_out_data,
  output logic ep_out_ready,
  output logic ep_out_unget,
  output logic ep_out_release,
  // task file access
  output logic tf_rd_req,
  output logic [9:0] tf_rd_addr,
  input wire logic tf_rd_done,
  input wire logic [7:0] tf_rd_data
);
  localparam int LW = $clog2(DMA_FIFO_BYTES+1);

  // register bus state
  logic bvalid, next_bvalid, rvalid, next_rvalid;
  logic [1:0] bresp, next_bresp, rresp, next_rresp;
  logic [31:0] rdata, next_rdata;
  logic wr_take, rd_take;

  // control state
  dsc_state_e state, next_state;
  dsc_ctrl_s ctrl, next_ctrl;
  logic halting, next_halting;
  logic [31:0] xfer_byte_counter, next_xfer_byte_counter;
  logic [IRQ_BITS-1:0] irq_status, next_irq_status, irq_mask, next_irq_mask, irq_set;
  logic [7:0] tf_data, next_tf_data;
  logic [9:0] tf_addr_q, next_tf_addr;
  logic out_full, next_out_full;
  logic [7:0] out_byte, next_out_byte;
  logic unget, next_unget, release_q, next_release;

  // datapath strobes
  logic in_push, out_take, out_load, byte_moved;
  logic [LW-1:0] fifo_level;
  logic fifo_in_ready;
  logic fifo_empty;
  logic cmd_wr, ctrl_wr, start_req;
  logic [7:0] cmd_code;
  logic last_byte;

  // in-direction dma fifo, drained every cycle the endpoint accepts
  dsc_byte_fifo #(
    .WIDTH(8),
    .DEPTH(DMA_FIFO_BYTES)
  ) u_in_fifo (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .in_valid(in_push),
    .in_ready(fifo_in_ready),
    .in_data(dma_in_data),
    .out_valid(ep_in_valid),
    .out_ready(ep_in_ready),
    .out_data(ep_in_data),
    .level(fifo_level)
  );

  // one byte taken from the dma bus per data cycle
  assign dma_in_ready = (state == ST_RUN) && ctrl.dir_in && fifo_in_ready;
  assign in_push = dma_in_valid & dma_in_ready;
  assign fifo_empty = (fifo_level == '0);

  // out stage holds one byte taken from the endpoint until the dma bus takes it or a halt hands it back to the endpoint
  assign dma_out_valid = out_full;
  assign dma_out_data = out_byte;
  assign out_take = out_full & dma_out_ready;
  // no fetch once the last counted byte leaves, or an extra byte would go out in drain
  assign ep_out_ready = (state == ST_RUN) && !ctrl.dir_in && (!out_full || dma_out_ready) && !last_byte;
  assign out_load = ep_out_valid & ep_out_ready;
  assign ep_out_unget = unget;
  assign ep_out_release = release_q;

  assign byte_moved = in_push | out_take;
  assign last_byte = ctrl.count_en && byte_moved && (xfer_byte_counter == 32'h0000_0001);

  assign tf_rd_req = (state == ST_TF_REQ) || (state == ST_TF_WAIT);
  assign tf_rd_addr = tf_addr_q;
  assign irq = |(irq_status & irq_mask);

  // axi handshake: write address and data taken together, one response at a time
  assign wr_take = s_axi_awvalid & s_axi_wvalid & ~bvalid;
  assign s_axi_awready = wr_take;
  assign s_axi_wready = wr_take;
  assign rd_take = s_axi_arvalid & ~rvalid;
  assign s_axi_arready = ~rvalid;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;

  assign cmd_wr = wr_take && (s_axi_awaddr == OFS_CMD) && s_axi_wstrb[0];
  assign cmd_code = s_axi_wdata[7:0];
  assign ctrl_wr = wr_take && (s_axi_awaddr == OFS_CTRL) && s_axi_wstrb[0];
  assign start_req = ctrl_wr && s_axi_wdata[CTRL_START_BIT];

  // address decode and read mux
  always_comb begin
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rresp = rresp;
    next_rdata = rdata;
    if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (wr_take) begin
      next_bvalid = 1'b1;
      unique case (s_axi_awaddr)
        OFS_CMD, OFS_XFER_COUNT, OFS_CTRL, OFS_IRQ_STATUS, OFS_IRQ_MASK: next_bresp = RESP_OKAY;
        default: next_bresp = RESP_SLVERR;
      endcase
    end
    if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (rd_take) begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      unique case (s_axi_araddr)
        OFS_CMD: next_rdata = 32'h0000_0000;
        OFS_XFER_COUNT: next_rdata = xfer_byte_counter;
        OFS_CTRL: next_rdata = {29'h0000_0000, ctrl.count_en, ctrl.dir_in, 1'b0};
        OFS_IRQ_STATUS: next_rdata = {29'h0000_0000, irq_status};
        OFS_IRQ_MASK: next_rdata = {29'h0000_0000, irq_mask};
        OFS_STATUS: next_rdata = {20'h0_0000, 4'(fifo_level), 1'b0, out_full, halting, 2'h0, state};
        OFS_TF_DATA: next_rdata = {24'h00_0000, tf_data};
        default: begin
          next_rdata = 32'h0000_0000;
          next_rresp = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      rvalid <= 1'b0;
      rresp <= RESP_OKAY;
      rdata <= 32'h0000_0000;
    end else begin
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
    end
  end

  // sequencer: generic transfer, halt, drain and task file reads
  always_comb begin
    next_state = state;
    next_ctrl = ctrl;
    next_halting = halting;
    next_tf_addr = tf_addr_q;
    next_tf_data = tf_data;
    next_unget = 1'b0;
    next_release = 1'b0;
    next_out_full = out_full;
    next_out_byte = out_byte;
    irq_set = '0;
    if (out_take) begin
      next_out_full = 1'b0;
    end
    if (out_load) begin
      next_out_full = 1'b1;
      next_out_byte = ep_out_data;
    end
    unique case (state)
      ST_IDLE: begin
        if (ctrl_wr) begin
          next_ctrl.dir_in = s_axi_wdata[CTRL_DIR_IN_BIT];
          next_ctrl.count_en = s_axi_wdata[CTRL_COUNT_EN_BIT];
        end
        if (start_req) begin
          next_state = ST_RUN;
          next_halting = 1'b0;
        end else if (cmd_wr && cmd_code == CMD_GENERIC_HALT) begin
          irq_set[IRQ_HALT_DONE] = 1'b1;
        end else if (cmd_wr && cmd_code >= CMD_TF_FIRST && cmd_code <= CMD_TF_LAST) begin
          next_tf_addr = dsc_tf_addr(cmd_code);
          next_state = ST_TF_REQ;
        end
        // any other code, reserved included, starts nothing
      end
      ST_RUN: begin
        if (cmd_wr && cmd_code == CMD_GENERIC_HALT) begin
          next_state = ST_DRAIN;
          next_halting = 1'b1;
          if (!ctrl.dir_in) begin
            // staged byte goes back so the endpoint keeps it
            next_unget = next_out_full;
            next_out_full = 1'b0;
          end
        end else if (last_byte) begin
          next_state = ST_DRAIN;
        end
      end
      ST_DRAIN: begin
        // in: wait for the fifo to flush; out: wait for the stage to empty
        if (ctrl.dir_in ? fifo_empty : !out_full) begin
          next_state = ST_IDLE;
          if (halting) begin
            irq_set[IRQ_HALT_DONE] = 1'b1;
          end else begin
            irq_set[IRQ_XFER_DONE] = 1'b1;
            next_release = !ctrl.dir_in;
          end
        end
      end
      ST_TF_REQ: begin
        next_state = ST_TF_WAIT;
      end
      ST_TF_WAIT: begin
        if (tf_rd_done) begin
          next_tf_data = tf_rd_data;
          irq_set[IRQ_TF_DONE] = 1'b1;
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // counter, interrupt status and mask
  always_comb begin
    next_xfer_byte_counter = xfer_byte_counter;
    next_irq_status = irq_status;
    next_irq_mask = irq_mask;
    if (byte_moved) begin
      // free-running wrap when counting is off
      next_xfer_byte_counter = xfer_byte_counter - 32'h0000_0001;
    end
    if (wr_take && s_axi_awaddr == OFS_XFER_COUNT) begin
      for (int i = 0; i < 4; i++) begin
        if (s_axi_wstrb[i]) begin
          next_xfer_byte_counter[i*8 +: 8] = s_axi_wdata[i*8 +: 8];
        end
      end
    end
    if (usb_bus_reset) begin
      next_xfer_byte_counter = XFER_COUNT_RESET;
    end
    if (wr_take && s_axi_awaddr == OFS_IRQ_MASK && s_axi_wstrb[0]) begin
      next_irq_mask = s_axi_wdata[IRQ_BITS-1:0];
    end
    if (wr_take && s_axi_awaddr == OFS_IRQ_STATUS && s_axi_wstrb[0]) begin
      next_irq_status = irq_status & ~s_axi_wdata[IRQ_BITS-1:0];
    end
    // a set in the clearing cycle wins
    next_irq_status = next_irq_status | irq_set;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_IDLE;
      ctrl <= '0;
      halting <= 1'b0;
      tf_addr_q <= 10'h000;
      tf_data <= 8'h00;
      unget <= 1'b0;
      release_q <= 1'b0;
      out_full <= 1'b0;
      out_byte <= 8'h00;
      xfer_byte_counter <= XFER_COUNT_RESET;
      irq_status <= '0;
      irq_mask <= IRQ_MASK_RESET;
    end else begin
      state <= next_state;
      ctrl <= next_ctrl;
      halting <= next_halting;
      tf_addr_q <= next_tf_addr;
      tf_data <= next_tf_data;
      unget <= next_unget;
      release_q <= next_release;
      out_full <= next_out_full;
      out_byte <= next_out_byte;
      xfer_byte_counter <= next_xfer_byte_counter;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
    end
  end
endmodule : dsc_dma_core

// >>> dsc_dma_core_props.sv
`timescale 1ns/100ps
module dsc_dma_core_props
  import dsc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_awready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic dma_in_valid,
  input wire logic dma_in_ready,
  input wire logic ep_in_valid,
  input wire logic ep_in_ready,
  input wire logic dma_out_valid,
  input wire logic [7:0] dma_out_data,
  input wire logic dma_out_ready,
  input wire logic ep_out_release,
  input wire logic ep_out_unget,
  input wire logic tf_rd_req,
  input wire logic [9:0] tf_rd_addr,
  input wire logic tf_rd_done
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // shadow of the in fifo fill, counted from both handshakes
  logic [4:0] lvl;
  logic [4:0] next_lvl;
  always_comb begin
    next_lvl = lvl + 5'(dma_in_valid && dma_in_ready) - 5'(ep_in_valid && ep_in_ready);
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) lvl <= 5'h00;
    else lvl <= next_lvl;
  end
  sequence s_wr_take;
    s_axi_awvalid && s_axi_wvalid && s_axi_awready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_wr_answer: assert property (s_wr_take |=> s_axi_bvalid)
    else $error("write not answered");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read not answered");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_tf_hold: assert property (tf_rd_req && !tf_rd_done |=> tf_rd_req && $stable(tf_rd_addr))
    else $error("task file request dropped");
  a_tf_addr_set: assert property (tf_rd_req |-> tf_rd_addr inside {10'h1F1, 10'h1F2, 10'h1F3, 10'h1F4,
    10'h1F5, 10'h1F6, 10'h3F6, 10'h3F7})
    else $error("task file address illegal");
  a_tf_end: assert property (tf_rd_req && tf_rd_done |=> !tf_rd_req)
    else $error("task file request stuck");
  a_in_forward: assert property (dma_in_valid && dma_in_ready |=> ep_in_valid)
    else $error("in byte late at endpoint");
  a_fifo_full: assert property (lvl >= 5'h08 |-> !dma_in_ready)
    else $error("in fifo over 8 bytes");
  // a halt may withdraw the staged byte, but only by handing it back to the endpoint
  a_out_hold: assert property (dma_out_valid && !dma_out_ready |=>
    (dma_out_valid && $stable(dma_out_data)) || ep_out_unget)
    else $error("out byte lost");
  a_unget_clear: assert property (ep_out_unget |-> !dma_out_valid)
    else $error("byte handed back but still offered");
  a_release_empty: assert property (ep_out_release |-> !dma_out_valid)
    else $error("release with byte staged");
endmodule : dsc_dma_core_props
bind dsc_dma_core dsc_dma_core_props u_props (.*);

// >>> dsc_dma_core_tb.sv
`timescale 1ns/100ps
module dsc_dma_core_tb;
  import dsc_pkg::*;
  logic sys_clk = 1'b0, rstn = 1'b0, usb_bus_reset = 1'b0, slow = 1'b0, ep_hold = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, dma_in_data = 8'h00, ep_out_data;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0, s_axi_bready = 1'b1;
  logic s_axi_rready = 1'b1, dma_in_valid = 1'b0, ep_in_ready = 1'b0, ep_out_valid = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic dma_in_ready, dma_out_valid, dma_out_ready, ep_in_valid, ep_out_ready, ep_out_unget;
  logic ep_out_release, tf_rd_req, tf_rd_done;
  logic [7:0] dma_out_data, ep_in_data, tf_rd_data;
  logic [9:0] tf_rd_addr;
  logic [7:0] ep_buf [256];
  logic [7:0] ep_q[$];
  int ep_idx = 0, n_rel = 0, n_errors = 0, samples_checked = 0;
  dsc_dma_core u_dut (.*);
  dsc_far_model u_far (.*);
  initial forever #25 sys_clk = ~sys_clk;
  assign ep_out_data = ep_buf[ep_idx[7:0]];
  // endpoint buffer side; in side stalls at random, out pointer steps back on unget
  always @(posedge sys_clk) begin
    if (ep_in_valid && ep_in_ready) ep_q.push_back(ep_in_data);
    ep_in_ready <= !ep_hold && ($urandom % 3 != 0);
    if (!ep_out_valid || ep_out_ready) ep_out_valid <= ($urandom % 2 == 0);
    if (ep_out_valid && ep_out_ready) ep_idx <= ep_idx + 1;
    if (ep_out_unget) ep_idx <= ep_idx - 1;
    if (ep_out_release) n_rel <= n_rel + 1;
  end
  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // every wait is bounded; running out ends the run as a mismatch
  task automatic guard(inout int n);
    if (++n > 2000) begin
      n_errors++;
      finish_test();
    end
    @(posedge sys_clk);
  endtask : guard
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do guard(n); while (s_axi_awready !== 1'b1 || s_axi_wready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do guard(n); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
  endtask : wr
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, 4'hF, r);
  endtask : w
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do guard(n); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do guard(n); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask : rd
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, e);
  endtask : rchk
  task automatic wait_irq();
    int n;
    n = 0;
    do guard(n); while (irq !== 1'b1);
  endtask : wait_irq
  task automatic push_in(input logic [7:0] b);
    int n;
    n = 0;
    dma_in_data <= b;
    dma_in_valid <= 1'b1;
    do guard(n); while (dma_in_ready !== 1'b1);
    dma_in_valid <= 1'b0;
    dma_in_data <= ~b;
    @(posedge sys_clk);
  endtask : push_in
  task automatic tend(input string s);
    $display("test %s done, mismatches %0d", s, n_errors);
  endtask : tend
  function automatic logic [9:0] tf_exp(input int i);
    logic [9:0] t [8];
    t = '{10'h1F1, 10'h1F2, 10'h1F3, 10'h1F4, 10'h1F5, 10'h1F6, 10'h3F6, 10'h3F7};
    return t[i];
  endfunction : tf_exp
  initial begin
    logic [31:0] d, e;
    logic [1:0] r;
    logic [7:0] sent [8];
    logic [7:0] rsv [5];
    int base;
    void'($urandom(8495));
    foreach (ep_buf[i]) ep_buf[i] = 8'($urandom);
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    rchk(OFS_XFER_COUNT, XFER_COUNT_RESET);
    rd(8'h3C, d, r);
    chk(r, RESP_SLVERR);
    chk(d, 32'h0);
    e = $urandom;
    w(OFS_XFER_COUNT, e);
    for (int i = 0; i < 4; i++) begin
      d = $urandom;
      wr(OFS_XFER_COUNT, d, 4'(4'h1 << i), r);
      chk(r, RESP_OKAY);
      e[8*i +: 8] = d[8*i +: 8];
      rchk(OFS_XFER_COUNT, e);
    end
    usb_bus_reset <= 1'b1;
    @(posedge sys_clk);
    usb_bus_reset <= 1'b0;
    rchk(OFS_XFER_COUNT, 32'h0);
    tend("counter lanes");
    // halt while idle, masked then unmasked then cleared
    w(OFS_CMD, CMD_GENERIC_HALT);
    repeat (2) @(posedge sys_clk);
    chk(irq, 32'h0);
    rchk(OFS_IRQ_STATUS, 32'h1);
    w(OFS_IRQ_MASK, 32'h7);
    chk(irq, 32'h1);
    w(OFS_IRQ_STATUS, 32'h1);
    chk(irq, 32'h0);
    for (int i = 0; i < 8; i++) begin
      slow <= i[0];
      w(OFS_CMD, CMD_TF_FIRST + 8'(i));
      wait_irq();
      e = 32'(tf_exp(i));
      chk(u_far.last_addr, e);
      rchk(OFS_TF_DATA, {24'h0, e[7:0] ^ 8'h5A});
      rchk(OFS_IRQ_STATUS, 32'h2);
      w(OFS_IRQ_STATUS, 32'h2);
    end
    tend("task file");
    rsv = '{8'h14, 8'h20, 8'h29, 8'hFF, 8'(8'h29 + $urandom % 215)};
    foreach (rsv[k]) begin
      w(OFS_CMD, rsv[k]);
      repeat (4) @(posedge sys_clk);
      chk(tf_rd_req, 32'h0);
      rchk(OFS_IRQ_STATUS, 32'h0);
    end
    tend("reserved");
    // counted in transfer with a mid-run counter read
    ep_q.delete();
    w(OFS_XFER_COUNT, 32'h5);
    w(OFS_CTRL, 32'h7);
    for (int i = 0; i < 5; i++) begin
      sent[i] = $urandom;
      push_in(sent[i]);
      if (i == 1) rchk(OFS_XFER_COUNT, 32'h3);
    end
    wait_irq();
    rchk(OFS_IRQ_STATUS, 32'h4);
    rchk(OFS_XFER_COUNT, 32'h0);
    for (int i = 0; i < 5; i++) chk(ep_q[i], sent[i]);
    w(OFS_IRQ_STATUS, 32'h7);
    // endpoint stalled: fill the fifo until refused, count uncounted, then halt
    ep_hold <= 1'b1;
    w(OFS_XFER_COUNT, 32'h2);
    ep_q.delete();
    w(OFS_CTRL, 32'h3);
    for (int i = 0; i < 8; i++) begin
      sent[i] = $urandom;
      push_in(sent[i]);
    end
    chk(dma_in_ready, 32'h0);
    rchk(OFS_XFER_COUNT, 32'hFFFF_FFFA);
    w(OFS_CMD, CMD_GENERIC_HALT);
    ep_hold <= 1'b0;
    wait_irq();
    rchk(OFS_IRQ_STATUS, 32'h1);
    for (int i = 0; i < 8; i++) chk(ep_q[i], sent[i]);
    w(OFS_IRQ_STATUS, 32'h7);
    tend("in path");
    base = ep_idx;
    w(OFS_XFER_COUNT, 32'h4);
    w(OFS_CTRL, 32'h5);
    wait_irq();
    rchk(OFS_IRQ_STATUS, 32'h4);
    chk(n_rel, 32'h1);
    chk(ep_idx - base, 32'h4);
    for (int i = 0; i < 4; i++) chk(u_far.got[i], ep_buf[8'(base + i)]);
    w(OFS_IRQ_STATUS, 32'h7);
    // slow far side, halted mid-stream: unmoved bytes stay in the endpoint
    slow <= 1'b1;
    u_far.got.delete();
    base = ep_idx;
    w(OFS_XFER_COUNT, 32'h32);
    w(OFS_CTRL, 32'h5);
    repeat (20) @(posedge sys_clk);
    w(OFS_CMD, CMD_GENERIC_HALT);
    wait_irq();
    rchk(OFS_IRQ_STATUS, 32'h1);
    chk(ep_idx - base, u_far.got.size());
    chk(n_rel, 32'h1);
    tend("out path");
    finish_test();
  end
endmodule : dsc_dma_core_tb

// >>> dsc_far_model.sv
`timescale 1ns/100ps
module dsc_far_model
  import dsc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic slow,
  input wire logic tf_rd_req,
  input wire logic [9:0] tf_rd_addr,
  output logic tf_rd_done,
  output logic [7:0] tf_rd_data,
  input wire logic dma_out_valid,
  input wire logic [7:0] dma_out_data,
  output logic dma_out_ready
);
  logic [7:0] got[$];
  logic [9:0] last_addr;
  int wait_n;
  // answers task file reads late when slow; data inverts after the strobe
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tf_rd_done <= 1'b0;
      tf_rd_data <= 8'h00;
      dma_out_ready <= 1'b0;
      wait_n <= 0;
    end else begin
      dma_out_ready <= slow ? ($urandom % 4 == 0) : 1'b1;
      if (dma_out_valid && dma_out_ready) got.push_back(dma_out_data);
      if (tf_rd_done) begin
        tf_rd_done <= 1'b0;
        tf_rd_data <= ~tf_rd_data;
      end else if (tf_rd_req) begin
        wait_n <= wait_n + 1;
        if (wait_n >= (slow ? 6 : 0)) begin
          tf_rd_done <= 1'b1;
          tf_rd_data <= tf_rd_addr[7:0] ^ 8'h5A;
          last_addr <= tf_rd_addr;
          wait_n <= 0;
        end
      end
    end
  end
endmodule : dsc_far_model

// >>> dsc_pkg.sv
package dsc_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CMD = 8'h30;
  localparam logic [7:0] OFS_XFER_COUNT = 8'h34;
  localparam logic [7:0] OFS_CTRL = 8'h40;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h44;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h48;
  localparam logic [7:0] OFS_STATUS = 8'h4C;
  localparam logic [7:0] OFS_TF_DATA = 8'h50;
  // command codes
  localparam logic [7:0] CMD_GENERIC_HALT = 8'h13;
  localparam logic [7:0] CMD_TF_FIRST = 8'h21;
  localparam logic [7:0] CMD_TF_LAST = 8'h28;
  // ctrl register bit positions
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_DIR_IN_BIT = 1;
  localparam int CTRL_COUNT_EN_BIT = 2;
  // interrupt bit positions
  localparam int IRQ_HALT_DONE = 0;
  localparam int IRQ_TF_DONE = 1;
  localparam int IRQ_XFER_DONE = 2;
  localparam int IRQ_BITS = 3;
  // reset values
  localparam logic [31:0] XFER_COUNT_RESET = 32'h0000_0000;
  localparam logic [IRQ_BITS-1:0] IRQ_MASK_RESET = 3'h0;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int FIFO_DRAIN_MAX_NS = 60;
  localparam int FIFO_DRAIN_CYCLES = (FIFO_DRAIN_MAX_NS / CLK_PERIOD_NS < 1) ? 1 :
                                     FIFO_DRAIN_MAX_NS / CLK_PERIOD_NS;
  localparam int DMA_FIFO_BYTES = 8;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RUN = 3'h1,
    ST_DRAIN = 3'h3,
    ST_TF_REQ = 3'h2,
    ST_TF_WAIT = 3'h6
  } dsc_state_e;

  typedef struct packed {
    logic count_en;
    logic dir_in;
  } dsc_ctrl_s;

  // map a task file read command onto its register address
  function automatic logic [9:0] dsc_tf_addr(input logic [7:0] code);
    logic [9:0] addr;
    addr = 10'h1F1;
    unique case (code)
      8'h21: addr = 10'h1F1;
      8'h22: addr = 10'h1F2;
      8'h23: addr = 10'h1F3;
      8'h24: addr = 10'h1F4;
      8'h25: addr = 10'h1F5;
      8'h26: addr = 10'h1F6;
      8'h27: addr = 10'h3F6;
      default: addr = 10'h3F7;
    endcase
    return addr;
  endfunction : dsc_tf_addr
endpackage : dsc_pkg
